// File: hdl/host_cfg_pkg.sv
// Package with offsets, field positions, reset values and counts for the host config register banks
package host_cfg_pkg;
    localparam logic [3:0] BANK_SEL_OFS = 4'h0_00E;
    localparam logic [5:0] BANK_MAC = 6'h0_002;
    localparam logic [5:0] BANK_CTRL = 6'h0_003;
    localparam logic [3:0] MAC_MID_OFS = 4'h0_002;
    localparam logic [3:0] MAC_HIGH_OFS = 4'h0_004;
    localparam logic [3:0] BUS_SPEED_OFS = 4'h0_000;
    localparam logic [3:0] ROM_PORT_OFS = 4'h0_002;
    localparam logic [3:0] SELFTEST_OFS = 4'h0_004;
    localparam logic [3:0] SOFT_RESET_OFS = 4'h0_006;
    localparam int ROM_SW_EN_BIT = 4;
    localparam int ROM_DIN_BIT = 3;
    localparam int ROM_DOUT_BIT = 2;
    localparam int ROM_SCK_BIT = 1;
    localparam int ROM_CS_BIT = 0;
    localparam int TX_DONE_BIT = 12;
    localparam int TX_FAIL_BIT = 11;
    localparam int RX_DONE_BIT = 4;
    localparam int RX_FAIL_BIT = 3;
    localparam int CFG_SPEED_BIT = 1;
    localparam logic [1:0] SPEED_125 = 2'h0;
    localparam logic [1:0] SPEED_62P5 = 2'h1;
    localparam logic [1:0] SPEED_41P66 = 2'h2;
    localparam logic [1:0] SPEED_25 = 2'h3;
    localparam logic [5:0] BANK_RESET = 6'h0_000;
    localparam logic [15:0] MAC_RESET = 16'h0_000;
    localparam logic [2:0] ROM_BITS_RESET = 3'h0;
    localparam logic [1:0] SPEED_RESET = 2'h0;
    localparam logic [15:0] BASE_ADDR_DEFAULT = 16'h0_300;
    localparam logic [3:0] ROM_WORD_BASE = 4'h0;
    localparam logic [3:0] ROM_WORD_MAC_MID = 4'h2;
    localparam logic [3:0] ROM_WORD_MAC_HIGH = 4'h3;
    localparam logic [3:0] ROM_WORD_CFG = 4'h6;
    localparam int ROM_WORD_W = 16;
    localparam int ROM_CMD_W = 9;
    localparam logic [2:0] ROM_READ_OP = 3'h6;
endpackage : host_cfg_pkg

// File: hdl/rom_loader.sv
// Serial EEPROM loader that fetches base address, MAC words and config word after reset
`timescale 1ns/1ps
`default_nettype none
module rom_loader #(
    parameter int CLK_DIV = 4
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clkEn,
    input wire logic start,
    input wire logic romDataIn,
    output logic romCs,
    output logic romSck,
    output logic romDout,
    output logic wordValid,
    output logic [3:0] wordAddr,
    output logic [15:0] wordData,
    output logic busy
);
    typedef enum logic [1:0] {
        L_IDLE = 2'b00,
        L_SHIFT = 2'b01,
        L_GAP = 2'b10
    } load_state_t;
    load_state_t state_reg;
    logic [7:0] divCnt_reg;
    logic [4:0] bitCnt_reg;
    logic [2:0] wordIdx_reg;
    logic [15:0] cmdShift_reg;
    logic [15:0] dataShift_reg;
    logic tick;
    logic [3:0] curAddr;
    assign tick = (divCnt_reg == 8'(CLK_DIV - 1));
    always_comb begin
        unique case (wordIdx_reg)
            3'd0: curAddr = host_cfg_pkg::ROM_WORD_BASE;
            3'd1: curAddr = host_cfg_pkg::ROM_WORD_MAC_MID;
            3'd2: curAddr = host_cfg_pkg::ROM_WORD_MAC_HIGH;
            default: curAddr = host_cfg_pkg::ROM_WORD_CFG;
        endcase
    end
    // One word per frame: read opcode, 6-bit address, 16 data bits
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_reg <= L_IDLE;
            divCnt_reg <= 8'h00;
            bitCnt_reg <= 5'd0;
            wordIdx_reg <= 3'd0;
            cmdShift_reg <= 16'h0000;
            dataShift_reg <= 16'h0000;
            romCs <= 1'b0;
            romSck <= 1'b0;
            romDout <= 1'b0;
            wordValid <= 1'b0;
            wordAddr <= 4'h0;
            wordData <= 16'h0000;
            busy <= 1'b0;
        end else if (clkEn) begin
            wordValid <= 1'b0;
            divCnt_reg <= tick ? 8'h00 : divCnt_reg + 8'h01;
            unique case (state_reg)
                L_IDLE: begin
                    romCs <= 1'b0;
                    romSck <= 1'b0;
                    if (start) begin
                        busy <= 1'b1;
                        wordIdx_reg <= 3'd0;
                        state_reg <= L_GAP;
                    end
                end
                L_GAP: if (tick) begin
                    if (wordIdx_reg == 3'd4) begin
                        busy <= 1'b0;
                        state_reg <= L_IDLE;
                    end else begin
                        romCs <= 1'b1;
                        // First bit is set up a half period ahead of the first rising clock
                        romDout <= host_cfg_pkg::ROM_READ_OP[2];
                        cmdShift_reg <= {host_cfg_pkg::ROM_READ_OP[1:0], 2'b00, curAddr, 8'h00};
                        bitCnt_reg <= 5'd0;
                        state_reg <= L_SHIFT;
                    end
                end
                L_SHIFT: if (tick) begin
                    romSck <= ~romSck;
                    if (!romSck) begin
                        // Sampled just before the rise, after the part has held the bit a full period
                        if (bitCnt_reg >= 5'(host_cfg_pkg::ROM_CMD_W)) begin
                            dataShift_reg <= {dataShift_reg[14:0], romDataIn};
                        end
                    end else begin
                        // Data out moves on the fall so it never changes with the rising clock
                        romDout <= cmdShift_reg[15];
                        cmdShift_reg <= {cmdShift_reg[14:0], 1'b0};
                        bitCnt_reg <= bitCnt_reg + 5'd1;
                        if (bitCnt_reg == 5'(host_cfg_pkg::ROM_CMD_W + host_cfg_pkg::ROM_WORD_W - 1)) begin
                            romCs <= 1'b0;
                            wordValid <= 1'b1;
                            wordAddr <= curAddr;
                            wordData <= dataShift_reg;
                            wordIdx_reg <= wordIdx_reg + 3'd1;
                            state_reg <= L_GAP;
                        end
                    end
                end
                default: state_reg <= L_IDLE;
            endcase
        end
    end
endmodule : rom_loader
`default_nettype wire

// File: hdl/host_cfg_reg_banks.sv
// Banked host configuration registers: MAC words, bus speed, EEPROM port, self-test flags, soft reset
`timescale 1ns/1ps
`default_nettype none
module host_cfg_reg_banks #(
    parameter int ROM_CLK_DIV = 4
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clkEn,
    input wire logic rom_enable_strap,
    input wire logic [3:0] hostAddr,
    input wire logic hostWrite,
    input wire logic hostRead,
    input wire logic [15:0] hostWdata,
    output logic [15:0] hostRdata,
    input wire logic rom_data_in_pin,
    output logic rom_data_out_pin,
    output logic rom_serial_clock_pin,
    output logic rom_chip_select_pin,
    input wire logic tx_buf_test_done,
    input wire logic tx_buf_test_failed,
    input wire logic rx_buf_test_done,
    input wire logic rx_buf_test_failed,
    output logic [1:0] internal_bus_speed_sel,
    output logic [15:0] baseAddr,
    output logic [15:0] mac_mid_word,
    output logic [15:0] mac_high_word,
    output logic softResetActive,
    output logic loaderBusy
);
    logic [5:0] bank_select_field;
    logic [2:0] rom_port_bits;
    logic rom_sw_access_en;
    logic strapSeen_reg;
    logic loadStart;
    logic ldCs, ldSck, ldDout, ldValid;
    logic [3:0] ldAddr;
    logic [15:0] ldData;
    logic selBank, wrMac, wrCtrl;
    logic [15:0] rdNext;

    assign selBank = (hostAddr == host_cfg_pkg::BANK_SEL_OFS);
    assign wrMac = hostWrite && !selBank && bank_select_field == host_cfg_pkg::BANK_MAC;
    assign wrCtrl = hostWrite && !selBank && bank_select_field == host_cfg_pkg::BANK_CTRL;

    // Bank select decoded ahead of the bank, so it is reachable from every bank
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            bank_select_field <= host_cfg_pkg::BANK_RESET;
        end else if (clkEn && hostWrite && selBank) begin
            bank_select_field <= hostWdata[5:0];
        end
    end

    // Strap is sampled by a clocked process after reset release, never inside reset
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            strapSeen_reg <= 1'b0;
        end else if (clkEn) begin
            strapSeen_reg <= 1'b1;
        end
    end
    assign loadStart = clkEn && !strapSeen_reg && rom_enable_strap;

    rom_loader #(
        .CLK_DIV(ROM_CLK_DIV)
    ) u_loader (
        .ref_clk(ref_clk),
        .rst(rst),
        .clkEn(clkEn),
        .start(loadStart),
        .romDataIn(rom_data_in_pin),
        .romCs(ldCs),
        .romSck(ldSck),
        .romDout(ldDout),
        .wordValid(ldValid),
        .wordAddr(ldAddr),
        .wordData(ldData),
        .busy(loaderBusy)
    );

    // Base address lives in the bus interface and ignores the soft reset
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            baseAddr <= host_cfg_pkg::BASE_ADDR_DEFAULT;
        end else if (clkEn && ldValid && ldAddr == host_cfg_pkg::ROM_WORD_BASE) begin
            baseAddr <= ldData;
        end
    end

    // Host write wins over a late loader word in the same cycle
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mac_mid_word <= host_cfg_pkg::MAC_RESET;
            mac_high_word <= host_cfg_pkg::MAC_RESET;
        end else if (clkEn) begin
            if (wrMac && hostAddr == host_cfg_pkg::MAC_MID_OFS) begin
                mac_mid_word <= hostWdata;
            end else if (ldValid && ldAddr == host_cfg_pkg::ROM_WORD_MAC_MID) begin
                mac_mid_word <= ldData;
            end
            if (wrMac && hostAddr == host_cfg_pkg::MAC_HIGH_OFS) begin
                mac_high_word <= hostWdata;
            end else if (ldValid && ldAddr == host_cfg_pkg::ROM_WORD_MAC_HIGH) begin
                mac_high_word <= ldData;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            internal_bus_speed_sel <= host_cfg_pkg::SPEED_RESET;
        end else if (clkEn) begin
            if (wrCtrl && hostAddr == host_cfg_pkg::BUS_SPEED_OFS) begin
                internal_bus_speed_sel <= hostWdata[1:0];
            end else if (ldValid && ldAddr == host_cfg_pkg::ROM_WORD_CFG) begin
                internal_bus_speed_sel <= ldData[host_cfg_pkg::CFG_SPEED_BIT] ?
                    host_cfg_pkg::SPEED_25 : host_cfg_pkg::SPEED_125;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rom_sw_access_en <= 1'b0;
            rom_port_bits <= host_cfg_pkg::ROM_BITS_RESET;
        end else if (clkEn && wrCtrl && hostAddr == host_cfg_pkg::ROM_PORT_OFS) begin
            rom_sw_access_en <= hostWdata[host_cfg_pkg::ROM_SW_EN_BIT];
            rom_port_bits <= hostWdata[2:0];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            softResetActive <= 1'b0;
        end else if (clkEn && wrCtrl && hostAddr == host_cfg_pkg::SOFT_RESET_OFS) begin
            softResetActive <= hostWdata[0];
        end
    end

    // With software access on, pins follow the bits with no sequencing; otherwise the loader makes the edges
    always_comb begin
        if (rom_sw_access_en) begin
            rom_data_out_pin = rom_port_bits[host_cfg_pkg::ROM_DOUT_BIT];
            rom_serial_clock_pin = rom_port_bits[host_cfg_pkg::ROM_SCK_BIT];
            rom_chip_select_pin = rom_port_bits[host_cfg_pkg::ROM_CS_BIT];
        end else begin
            rom_data_out_pin = ldDout;
            rom_serial_clock_pin = ldSck;
            rom_chip_select_pin = ldCs;
        end
    end

    always_comb begin
        rdNext = 16'h0000;
        if (selBank) begin
            rdNext = {10'h000, bank_select_field};
        end else if (bank_select_field == host_cfg_pkg::BANK_MAC) begin
            if (hostAddr == host_cfg_pkg::MAC_MID_OFS) begin
                rdNext = mac_mid_word;
            end else if (hostAddr == host_cfg_pkg::MAC_HIGH_OFS) begin
                rdNext = mac_high_word;
            end
        end else if (bank_select_field == host_cfg_pkg::BANK_CTRL) begin
            unique case (hostAddr)
                host_cfg_pkg::BUS_SPEED_OFS: rdNext = {14'h0000, internal_bus_speed_sel};
                host_cfg_pkg::ROM_PORT_OFS: begin
                    rdNext[host_cfg_pkg::ROM_SW_EN_BIT] = rom_sw_access_en;
                    rdNext[host_cfg_pkg::ROM_DIN_BIT] = rom_data_in_pin;
                    rdNext[2:0] = rom_port_bits;
                end
                host_cfg_pkg::SELFTEST_OFS: begin
                    rdNext[host_cfg_pkg::TX_DONE_BIT] = tx_buf_test_done;
                    rdNext[host_cfg_pkg::TX_FAIL_BIT] = tx_buf_test_failed;
                    rdNext[host_cfg_pkg::RX_DONE_BIT] = rx_buf_test_done;
                    rdNext[host_cfg_pkg::RX_FAIL_BIT] = rx_buf_test_failed;
                end
                host_cfg_pkg::SOFT_RESET_OFS: rdNext = {15'h0000, softResetActive};
                default: rdNext = 16'h0000;
            endcase
        end
    end

    // Read data registered one cycle after the read strobe
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            hostRdata <= 16'h0000;
        end else if (clkEn && hostRead) begin
            hostRdata <= rdNext;
        end
    end

    a_bank_sel_write: assert property (@(posedge ref_clk) disable iff (rst)
        clkEn && hostWrite && selBank |=> bank_select_field == $past(hostWdata[5:0]))
        else $error("bank select not updated");
    a_bank_sel_hold: assert property (@(posedge ref_clk) disable iff (rst)
        !(clkEn && hostWrite && selBank)
        |=> $stable(bank_select_field))
        else $error("bank select changed without a write");
    a_bank_sel_read: assert property (@(posedge ref_clk) disable iff (rst)
        clkEn && hostRead && selBank
        |=> hostRdata == {10'h000, $past(bank_select_field)})
        else $error("bank select not readable");
    a_unmapped_zero: assert property (@(posedge ref_clk) disable iff (rst)
        clkEn && hostRead && !selBank && bank_select_field != host_cfg_pkg::BANK_MAC
        && bank_select_field != host_cfg_pkg::BANK_CTRL |=> hostRdata == 16'h0000)
        else $error("unmapped bank read not zero");
    a_mac_mid_write: assert property (@(posedge ref_clk) disable iff (rst)
        clkEn && wrMac && hostAddr == host_cfg_pkg::MAC_MID_OFS |=> mac_mid_word == $past(hostWdata))
        else $error("mac mid word not written");
    a_mac_high_write: assert property (@(posedge ref_clk) disable iff (rst)
        clkEn && wrMac && hostAddr == host_cfg_pkg::MAC_HIGH_OFS |=> mac_high_word == $past(hostWdata))
        else $error("mac high word not written");
    a_mac_hold: assert property (@(posedge ref_clk) disable iff (rst)
        !(clkEn && wrMac) && !(clkEn && ldValid)
        |=> $stable(mac_mid_word) && $stable(mac_high_word))
        else $error("mac word changed without a write");
    a_speed_write: assert property (@(posedge ref_clk) disable iff (rst)
        clkEn && wrCtrl && hostAddr == host_cfg_pkg::BUS_SPEED_OFS |=> internal_bus_speed_sel == $past(hostWdata[1:0]))
        else $error("speed field not writable");
    a_speed_hold: assert property (@(posedge ref_clk) disable iff (rst)
        !(clkEn && wrCtrl && hostAddr == host_cfg_pkg::BUS_SPEED_OFS)
        && !(clkEn && ldValid && ldAddr == host_cfg_pkg::ROM_WORD_CFG) |=> $stable(internal_bus_speed_sel))
        else $error("speed field changed on its own");
    a_speed_read: assert property (@(posedge ref_clk) disable iff (rst)
        clkEn && hostRead && !selBank && bank_select_field == host_cfg_pkg::BANK_CTRL
        && hostAddr == host_cfg_pkg::BUS_SPEED_OFS |=> hostRdata == {14'h0000, $past(internal_bus_speed_sel)})
        else $error("speed field read wrong");
    a_speed_load: assert property (@(posedge ref_clk) disable iff (rst)
        clkEn && ldValid && ldAddr == host_cfg_pkg::ROM_WORD_CFG && !wrCtrl
        |=> internal_bus_speed_sel == {2{$past(ldData[1])}})
        else $error("speed load wrong");
    a_base_hold: assert property (@(posedge ref_clk) disable iff (rst)
        !(clkEn && ldValid && ldAddr == host_cfg_pkg::ROM_WORD_BASE)
        |=> $stable(baseAddr))
        else $error("base address changed without a loader word");
    a_load_start: assert property (@(posedge ref_clk) disable iff (rst)
        clkEn && !strapSeen_reg && rom_enable_strap
        |=> loaderBusy)
        else $error("loader did not start after reset");
    a_no_strap_idle: assert property (@(posedge ref_clk) disable iff (rst)
        clkEn && !strapSeen_reg && !rom_enable_strap
        |=> !loaderBusy)
        else $error("loader started with strap low");
    a_sw_pins: assert property (@(posedge ref_clk) disable iff (rst)
        rom_sw_access_en |-> {rom_data_out_pin, rom_serial_clock_pin, rom_chip_select_pin} == rom_port_bits)
        else $error("sw pins not driven");
    a_port_bits_write: assert property (@(posedge ref_clk) disable iff (rst)
        clkEn && wrCtrl && hostAddr == host_cfg_pkg::ROM_PORT_OFS
        |=> rom_port_bits == $past(hostWdata[2:0]) && rom_sw_access_en == $past(hostWdata[4]))
        else $error("rom port bits not written");
    a_port_read: assert property (@(posedge ref_clk) disable iff (rst)
        clkEn && hostRead && !selBank && bank_select_field == host_cfg_pkg::BANK_CTRL
        && hostAddr == host_cfg_pkg::ROM_PORT_OFS
        |=> hostRdata[2:0] == $past(rom_port_bits) && hostRdata[4] == $past(rom_sw_access_en))
        else $error("rom port bits read wrong");
    a_loader_pins: assert property (@(posedge ref_clk) disable iff (rst)
        !rom_sw_access_en |-> rom_chip_select_pin == ldCs && rom_serial_clock_pin == ldSck)
        else $error("loader does not own pins");
    a_loader_dout: assert property (@(posedge ref_clk) disable iff (rst)
        !rom_sw_access_en |-> rom_data_out_pin == ldDout)
        else $error("loader does not own data out");
    a_din_live: assert property (@(posedge ref_clk) disable iff (rst)
        clkEn && hostRead && !selBank && bank_select_field == host_cfg_pkg::BANK_CTRL
        && hostAddr == host_cfg_pkg::ROM_PORT_OFS |=> hostRdata[3] == $past(rom_data_in_pin))
        else $error("data in not live");
    a_selftest_read: assert property (@(posedge ref_clk) disable iff (rst)
        clkEn && hostRead && !selBank && bank_select_field == host_cfg_pkg::BANK_CTRL
        && hostAddr == host_cfg_pkg::SELFTEST_OFS
        |=> hostRdata[12] == $past(tx_buf_test_done) && hostRdata[11] == $past(tx_buf_test_failed)
        && hostRdata[4] == $past(rx_buf_test_done) && hostRdata[3] == $past(rx_buf_test_failed))
        else $error("self test flags wrong");
    a_soft_reset: assert property (@(posedge ref_clk) disable iff (rst)
        clkEn && wrCtrl && hostAddr == host_cfg_pkg::SOFT_RESET_OFS |=> softResetActive == $past(hostWdata[0]))
        else $error("soft reset not following write");
    a_soft_reset_hold: assert property (@(posedge ref_clk) disable iff (rst)
        !(clkEn && wrCtrl && hostAddr == host_cfg_pkg::SOFT_RESET_OFS)
        |=> $stable(softResetActive))
        else $error("soft reset changed without a write");
    a_soft_reset_read: assert property (@(posedge ref_clk) disable iff (rst)
        clkEn && hostRead && !selBank && bank_select_field == host_cfg_pkg::BANK_CTRL
        && hostAddr == host_cfg_pkg::SOFT_RESET_OFS |=> hostRdata == {15'h0000, $past(softResetActive)})
        else $error("soft reset bit read wrong");
    a_base_kept: assert property (@(posedge ref_clk) disable iff (rst)
        softResetActive && !ldValid |=> $stable(baseAddr))
        else $error("base address disturbed");
endmodule : host_cfg_reg_banks
`default_nettype wire

// File: tb/rom_model.sv
// Serial configuration memory model that answers read frames on the rom port
`timescale 1ns/1ps
`default_nettype none
module rom_model (
    input wire logic ref_clk,
    input wire logic cs,
    input wire logic sck,
    input wire logic di,
    output logic dout
);
    logic [15:0] mem [0:63];
    logic [7:0] cmd;
    logic [15:0] shiftOut;
    logic idleBit = 1'h0;
    logic readOp = 1'h0;
    int edges = 0;
    // Command bits are taken on rising clock; data changes after rising clock
    always @(posedge sck or negedge cs) begin
        if (!cs) begin
            edges <= 0;
        end else begin
            edges <= edges + 1;
            cmd <= {cmd[6:0], di};
            if (edges == 8) begin
                readOp <= (cmd[7:5] == 3'h6);
                shiftOut <= mem[{cmd[4:0], di}];
            end else begin
                shiftOut <= {shiftOut[14:0], 1'h0};
            end
        end
    end
    // Undriven output toggles so a stray sample never looks like a stable bit
    always @(posedge ref_clk) begin
        idleBit <= ~idleBit;
    end
    assign dout = (cs && readOp && edges >= 9 && edges <= 24) ? shiftOut[15] : idleBit;
endmodule : rom_model
`default_nettype wire

// File: tb/tb.sv
// Self-checking bench for the banked host configuration registers
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checksDone++; if ((g) !== (e)) begin errorCnt++; $display("BAD t=%0t got %h exp %h", $time, g, e); end end
module tb;
    logic ref_clk;
    logic rst;
    logic clkEn;
    logic strap;
    logic [3:0] hostAddr;
    logic hostWrite;
    logic hostRead;
    logic [15:0] hostWdata;
    logic [15:0] hostRdata;
    logic romIn;
    logic romOut;
    logic romSck;
    logic romCs;
    logic [3:0] bist;
    logic [1:0] speed;
    logic [15:0] baseAddr;
    logic [15:0] macMid;
    logic [15:0] macHigh;
    logic softRst;
    logic loaderBusy;
    logic [15:0] v;
    logic [15:0] e;
    logic [8:0] cmdBits = 9'h183;
    int errorCnt = 0;
    int checksDone = 0;
    host_cfg_reg_banks #(.ROM_CLK_DIV(2)) dut (.ref_clk(ref_clk), .rst(rst), .clkEn(clkEn),
        .rom_enable_strap(strap), .hostAddr(hostAddr), .hostWrite(hostWrite), .hostRead(hostRead),
        .hostWdata(hostWdata), .hostRdata(hostRdata), .rom_data_in_pin(romIn), .rom_data_out_pin(romOut),
        .rom_serial_clock_pin(romSck), .rom_chip_select_pin(romCs), .tx_buf_test_done(bist[3]),
        .tx_buf_test_failed(bist[2]), .rx_buf_test_done(bist[1]), .rx_buf_test_failed(bist[0]),
        .internal_bus_speed_sel(speed), .baseAddr(baseAddr), .mac_mid_word(macMid),
        .mac_high_word(macHigh), .softResetActive(softRst), .loaderBusy(loaderBusy));
    rom_model eeprom (.ref_clk(ref_clk), .cs(romCs), .sck(romSck), .di(romOut), .dout(romIn));
    initial begin
        ref_clk = 1'h0;
        forever #25 ref_clk = ~ref_clk;
    end
    task automatic stop_test;
        $display("checks %0d errors %0d", checksDone, errorCnt);
        if (errorCnt == 0 && checksDone > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : stop_test
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        hostAddr <= a;
        hostWdata <= d;
        hostWrite <= 1'h1;
        @(posedge ref_clk);
        hostWrite <= 1'h0;
        @(posedge ref_clk);
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        hostAddr <= a;
        hostRead <= 1'h1;
        @(posedge ref_clk);
        hostRead <= 1'h0;
        @(posedge ref_clk);
        @(negedge ref_clk);
        d = hostRdata;
        @(posedge ref_clk);
    endtask : rd
    task automatic rdchk(input logic [3:0] a, input logic [15:0] x);
        logic [15:0] got;
        rd(a, got);
        `CHK(got, x)
    endtask : rdchk
    task automatic bank(input logic [5:0] n);
        wr(host_cfg_pkg::BANK_SEL_OFS, {10'h000, n});
    endtask : bank
    task automatic do_reset;
        @(posedge ref_clk);
        rst <= 1'h1;
        repeat (20) @(posedge ref_clk);
        rst <= 1'h0;
        @(posedge ref_clk);
    endtask : do_reset
    initial begin
        repeat (20000) @(posedge ref_clk);
        errorCnt++;
        stop_test();
    end
    initial begin
        rst = 1'h1;
        clkEn = 1'h1;
        strap = 1'h0;
        hostAddr = 4'h0;
        hostWrite = 1'h0;
        hostRead = 1'h0;
        hostWdata = 16'h0000;
        bist = 4'h0;
        do_reset();
        `CHK(speed, host_cfg_pkg::SPEED_RESET)
        `CHK(baseAddr, host_cfg_pkg::BASE_ADDR_DEFAULT)
        `CHK({romOut, romSck, romCs, loaderBusy}, 4'h0)
        bank(6'h02);
        rdchk(host_cfg_pkg::BANK_SEL_OFS, 16'h0002);
        wr(host_cfg_pkg::MAC_MID_OFS, 16'hBEEF);
        wr(host_cfg_pkg::MAC_HIGH_OFS, 16'h1357);
        rdchk(host_cfg_pkg::MAC_MID_OFS, 16'hBEEF);
        rdchk(host_cfg_pkg::MAC_HIGH_OFS, 16'h1357);
        `CHK({macMid, macHigh}, 32'hBEEF_1357)
        clkEn <= 1'h0;
        wr(host_cfg_pkg::MAC_MID_OFS, 16'h0000);
        clkEn <= 1'h1;
        `CHK(macMid, 16'hBEEF)
        bank(6'h00);
        rdchk(host_cfg_pkg::MAC_MID_OFS, 16'h0000);
        bank(6'h03);
        rdchk(host_cfg_pkg::BANK_SEL_OFS, 16'h0003);
        // Reserved bits are written as ones to catch a field that is too wide
        for (int c = 0; c < 4; c++) begin
            wr(host_cfg_pkg::BUS_SPEED_OFS, {14'h3FFF, 2'(c)});
            rdchk(host_cfg_pkg::BUS_SPEED_OFS, {14'h0000, 2'(c)});
            `CHK(speed, 2'(c))
        end
        wr(host_cfg_pkg::ROM_PORT_OFS, 16'h0007);
        `CHK({romOut, romSck, romCs}, 3'h0)
        rd(host_cfg_pkg::ROM_PORT_OFS, v);
        `CHK({v[15:4], v[2:0]}, 15'h0007)
        wr(host_cfg_pkg::ROM_PORT_OFS, 16'h0015);
        `CHK({romOut, romSck, romCs}, 3'h5)
        wr(host_cfg_pkg::ROM_PORT_OFS, 16'h0012);
        `CHK({romOut, romSck, romCs}, 3'h2)
        wr(host_cfg_pkg::ROM_PORT_OFS, 16'h0000);
        wr(host_cfg_pkg::SELFTEST_OFS, 16'hFFFF);
        for (int t = 0; t < 16; t++) begin
            bist <= 4'(t);
            e = 16'h0000;
            e[host_cfg_pkg::TX_DONE_BIT] = t[3];
            e[host_cfg_pkg::TX_FAIL_BIT] = t[2];
            e[host_cfg_pkg::RX_DONE_BIT] = t[1];
            e[host_cfg_pkg::RX_FAIL_BIT] = t[0];
            rdchk(host_cfg_pkg::SELFTEST_OFS, e);
        end
        wr(host_cfg_pkg::SOFT_RESET_OFS, 16'hFFFF);
        `CHK(softRst, 1'h1)
        rdchk(host_cfg_pkg::SOFT_RESET_OFS, 16'h0001);
        `CHK(baseAddr, host_cfg_pkg::BASE_ADDR_DEFAULT)
        wr(host_cfg_pkg::SOFT_RESET_OFS, 16'h0000);
        `CHK(softRst, 1'h0)
        bank(6'h02);
        rdchk(host_cfg_pkg::MAC_MID_OFS, 16'hBEEF);
        eeprom.mem[0] = 16'h0A40;
        eeprom.mem[2] = 16'h4567;
        eeprom.mem[3] = 16'h0123;
        strap <= 1'h1;
        // Both values of the speed bit, with every other config bit opposite
        for (int k = 0; k < 2; k++) begin
            eeprom.mem[6] = k ? 16'h0002 : 16'hFFFD;
            do_reset();
            repeat (2) @(posedge ref_clk);
            `CHK(loaderBusy, 1'h1)
            // Speed is moved off the loaded value first, so both codes of the load can be seen
            bank(6'h03);
            wr(host_cfg_pkg::BUS_SPEED_OFS, 16'h0001);
            for (int n = 0; n < 3000 && loaderBusy !== 1'h0; n++) @(posedge ref_clk);
            `CHK({baseAddr, macMid, macHigh}, 48'h0A40_4567_0123)
            `CHK(speed, k ? host_cfg_pkg::SPEED_25 : host_cfg_pkg::SPEED_125)
        end
        bank(6'h03);
        wr(host_cfg_pkg::BUS_SPEED_OFS, 16'h0001);
        `CHK(speed, host_cfg_pkg::SPEED_62P5)
        wr(host_cfg_pkg::ROM_PORT_OFS, 16'h0011);
        for (int i = 8; i >= 0; i--) begin
            wr(host_cfg_pkg::ROM_PORT_OFS, {11'h000, 1'h1, 1'h0, cmdBits[i], 2'h1});
            wr(host_cfg_pkg::ROM_PORT_OFS, {11'h000, 1'h1, 1'h0, cmdBits[i], 2'h3});
        end
        e = 16'h0123;
        for (int i = 15; i >= 0; i--) begin
            rd(host_cfg_pkg::ROM_PORT_OFS, v);
            `CHK(v[3], e[i])
            wr(host_cfg_pkg::ROM_PORT_OFS, 16'h0011);
            wr(host_cfg_pkg::ROM_PORT_OFS, 16'h0013);
        end
        wr(host_cfg_pkg::ROM_PORT_OFS, 16'h0000);
        stop_test();
    end
endmodule : tb
`default_nettype wire
